// ===== eep_pkg.sv
// Shared constants and types for the emulated EEPROM control register bank
package eep_pkg;
    // Register offsets (module base relative)
    localparam logic [3:0] OFS_CLKDIV = 4'h0;
    localparam logic [3:0] OFS_TEST_A = 4'h1;
    localparam logic [3:0] OFS_TEST_B = 4'h2;
    localparam logic [3:0] OFS_CONFIG = 4'h3;
    localparam logic [3:0] OFS_PROT = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h5;
    localparam logic [3:0] OFS_CMD = 4'h6;
    localparam logic [3:0] OFS_TEST_C = 4'h7;
    localparam logic [3:0] OFS_ADDR_HI = 4'h8;
    localparam logic [3:0] OFS_ADDR_LO = 4'h9;
    // Field positions
    localparam int DIV_LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int OPEN_BIT = 7;
    localparam int RANGE_DIS_BIT = 3;
    localparam int BE_IE_BIT = 7;
    localparam int CC_IE_BIT = 6;
    localparam int BE_FLAG_BIT = 7;
    localparam int CC_FLAG_BIT = 6;
    localparam int PROTECTION_VIOLATION_FLAG_BIT = 5;
    // Array geometry
    localparam logic [10:0] PROT_BYTE_ADDR = 11'h7FD;
    localparam logic [10:0] ARRAY_TOP = 11'h7FF;
    localparam int PROT_UNIT_BYTES = 64;
    localparam logic [2:0] PRESCALE_DIV = 3'h7;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [10:0] RST_ADDR = 11'h000;
    // Program/erase request toward the array engine
    typedef struct packed {
        logic valid;
        logic mass;
        logic [10:0] addr;
    } eep_req_t;
endpackage

// ===== eep_regs.sv
// Control, clock divider and sector protection registers of the emulated EEPROM
// Overview of operation
// [R1] Divider-loaded bit 7 shows a write happened
// [R2] Divider readable; bits 6-0 take first write
// [R3] Prescale bit divides oscillator by eight first
// [R4] Software keeps algorithm clock 150-200 kHz
// [R5] Factory test registers read zero, ignore writes
// [R6] Config: two enables read/write, rest zero
// [R7] Buffer-empty enable gates its interrupt request
// [R8] Complete enable gates its interrupt request
// [R9] Protection loaded from stored byte at reset
// [R10] User nonvolatile flags read-only, from stored byte
// [R11] Open and disable bits only clear
// [R12] Size bits lock once range protection on
// [R13] Open bit zero protects whole array
// [R14] Disable bit removes upper protected range
// [R15] Range ends 0x07FF, size (code+1)*64
// [R16] Protected program/erase refused, sets violation flag
// [R17] Mass erase needs open and disable set
// [R18] Software unprotects before rewriting protection byte
// [R19] Violation cleared by one, blocks launches
// [R20] Divider lock released only by reset
`timescale 1ns/1ps
module eep_regs
    import eep_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    input wire logic OSC_CLK_IN,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Stored protection byte, valid during reset
    input wire logic [7:0] PROT_BYTE,
    // Command engine side
    input wire eep_req_t CMD_REQ,
    input wire logic BUFFER_EMPTY,
    input wire logic COMMAND_COMPLETE,
    output eep_req_t CMD_GO,
    output logic CMD_REFUSED,
    output logic ALGO_TICK,
    output logic IRQ
);
    logic [6:0] div_ff;
    logic div_loaded_ff;
    logic [1:0] irq_en_ff;
    logic open_ff;
    logic [2:0] nv_ff;
    logic range_dis_ff;
    logic [2:0] size_ff;
    logic protection_violation_flag_ff;
    logic [7:0] cmd_ff;
    logic [10:0] taddr_ff;
    logic [7:0] rdata_ff;
    logic [2:0] pre_ff;
    logic [5:0] cnt_ff;
    logic tick_ff;
    eep_req_t go_ff;
    logic refused_ff;
    logic prev_osc_ff;
    logic osc_edge;
    logic prot_hit;
    logic refuse;
    logic [10:0] prot_base;

    function automatic logic sel(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction

    // Divider: first write wins until reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_ff <= 7'h00;
            div_loaded_ff <= 1'b0;
        end else if (WR && sel(ADDR, OFS_CLKDIV) && !div_loaded_ff) begin // see [R2] see [R20]
            div_ff <= WDATA[6:0];
            div_loaded_ff <= 1'b1; // see [R1]
        end
    end

    // Oscillator treated as sampled input; edge detect on a registered copy
    always_ff @(posedge CLK) begin
        if (RST) begin
            prev_osc_ff <= 1'b0;
        end else begin
            prev_osc_ff <= OSC_CLK_IN;
        end
    end
    assign osc_edge = OSC_CLK_IN && !prev_osc_ff;

    // Prescaler and six-bit divider give the algorithm tick
    always_ff @(posedge CLK) begin
        if (RST) begin
            pre_ff <= 3'h0;
            cnt_ff <= 6'h00;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            if (osc_edge && div_loaded_ff) begin
                if (div_ff[PRESCALE_BIT] && pre_ff != PRESCALE_DIV) begin // see [R3]
                    pre_ff <= pre_ff + 3'h1;
                end else begin
                    pre_ff <= 3'h0;
                    if (cnt_ff == div_ff[5:0]) begin
                        cnt_ff <= 6'h00;
                        tick_ff <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff + 6'h01;
                    end
                end
            end
        end
    end
    assign ALGO_TICK = tick_ff;

    // Interrupt enables
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_en_ff <= 2'b00;
        end else if (WR && sel(ADDR, OFS_CONFIG)) begin
            irq_en_ff <= WDATA[7:6]; // see [R6]
        end
    end
    assign IRQ = (irq_en_ff[1] && BUFFER_EMPTY) || (irq_en_ff[0] && COMMAND_COMPLETE); // see [R7] see [R8]

    // Protection register; reload from the array byte while reset is held
    always_ff @(posedge CLK) begin
        if (RST) begin
            open_ff <= PROT_BYTE[OPEN_BIT]; // see [R9]
            nv_ff <= PROT_BYTE[6:4]; // see [R10]
            range_dis_ff <= PROT_BYTE[RANGE_DIS_BIT];
            size_ff <= PROT_BYTE[2:0];
        end else if (WR && sel(ADDR, OFS_PROT)) begin
            open_ff <= open_ff & WDATA[OPEN_BIT]; // see [R11]
            range_dis_ff <= range_dis_ff & WDATA[RANGE_DIS_BIT];
            if (range_dis_ff) begin
                size_ff <= WDATA[2:0]; // see [R12]
            end
        end
    end

    // Lowest protected address: top minus (code+1)*64 plus one
    assign prot_base = ARRAY_TOP - {2'b00, size_ff, 6'h3F}; // see [R15]
    always_comb begin
        if (!open_ff) begin
            prot_hit = 1'b1; // see [R13]
        end else if (CMD_REQ.mass) begin
            prot_hit = !range_dis_ff; // see [R17]
        end else begin
            prot_hit = !range_dis_ff && (CMD_REQ.addr >= prot_base); // see [R14]
        end
    end
    assign refuse = CMD_REQ.valid && (prot_hit || protection_violation_flag_ff);

    // Violation flag: set wins over a same-cycle clear by one
    always_ff @(posedge CLK) begin
        if (RST) begin
            protection_violation_flag_ff <= 1'b0;
        end else if (CMD_REQ.valid && prot_hit) begin
            protection_violation_flag_ff <= 1'b1; // see [R16]
        end else if (WR && sel(ADDR, OFS_STATUS) && WDATA[PROTECTION_VIOLATION_FLAG_BIT]) begin
            protection_violation_flag_ff <= 1'b0; // see [R19]
        end
    end

    // Launch toward the array engine, refused ones never leave
    always_ff @(posedge CLK) begin
        if (RST) begin
            go_ff <= '0;
            refused_ff <= 1'b0;
        end else begin
            // Address and kind pass through; only valid is gated
            go_ff <= '{
                valid: CMD_REQ.valid && !refuse, // see [R19]
                mass: CMD_REQ.mass,
                addr: CMD_REQ.addr
            };
            refused_ff <= refuse;
        end
    end
    assign CMD_GO = go_ff;
    assign CMD_REFUSED = refused_ff;

    // Command and address holding registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            cmd_ff <= RST_ZERO;
            taddr_ff <= RST_ADDR;
        end else if (WR) begin
            if (sel(ADDR, OFS_CMD)) begin
                cmd_ff <= WDATA;
            end
            if (sel(ADDR, OFS_ADDR_HI)) begin
                taddr_ff[10:8] <= WDATA[2:0];
            end
            if (sel(ADDR, OFS_ADDR_LO)) begin
                taddr_ff[7:0] <= WDATA;
            end
        end
    end

    // Read mux; test registers and unmapped offsets read zero
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_ff <= RST_ZERO;
        end else if (RD) begin
            unique case (ADDR)
                OFS_CLKDIV: rdata_ff <= {div_loaded_ff, div_ff};
                OFS_CONFIG: rdata_ff <= {irq_en_ff, 6'h00};
                OFS_PROT: rdata_ff <= {open_ff, nv_ff, range_dis_ff, size_ff};
                OFS_STATUS: rdata_ff <= {BUFFER_EMPTY, COMMAND_COMPLETE, protection_violation_flag_ff, 5'h00};
                OFS_CMD: rdata_ff <= cmd_ff;
                OFS_ADDR_HI: rdata_ff <= {5'h00, taddr_ff[10:8]};
                OFS_ADDR_LO: rdata_ff <= taddr_ff[7:0];
                default: rdata_ff <= RST_ZERO; // see [R5]
            endcase
        end else begin
            rdata_ff <= RST_ZERO;
        end
    end
    assign RDATA = rdata_ff;

    // Checks
    sequence div_write_s;
        WR && sel(ADDR, OFS_CLKDIV);
    endsequence
    div_once_a: assert property (@(posedge CLK) disable iff (RST) // see [R2]
        div_write_s ##0 div_loaded_ff |=> $stable(div_ff))
        else $error("divider changed after first write");
    div_flag_a: assert property (@(posedge CLK) disable iff (RST) // see [R1]
        div_write_s |=> div_loaded_ff)
        else $error("loaded flag not set by write");
    test_zero_a: assert property (@(posedge CLK) disable iff (RST) // see [R5]
        RD && (sel(ADDR, OFS_TEST_A) || sel(ADDR, OFS_TEST_C)) |=> RDATA == 8'h00)
        else $error("test register read nonzero");
    irq_gate_a: assert property (@(posedge CLK) disable iff (RST) // see [R7]
        !irq_en_ff[1] && !irq_en_ff[0] |-> !IRQ)
        else $error("interrupt while disabled");
    open_sticky_a: assert property (@(posedge CLK) disable iff (RST) // see [R11]
        !open_ff |=> !open_ff)
        else $error("open bit set by software");
    size_lock_a: assert property (@(posedge CLK) disable iff (RST) // see [R12]
        !range_dis_ff |=> $stable(size_ff))
        else $error("size changed while locked");
    closed_refuse_a: assert property (@(posedge CLK) disable iff (RST) // see [R13]
        CMD_REQ.valid && !open_ff |=> CMD_REFUSED && !CMD_GO.valid && protection_violation_flag_ff)
        else $error("closed array accepted command");
    mass_erase_a: assert property (@(posedge CLK) disable iff (RST) // see [R17]
        CMD_REQ.valid && CMD_REQ.mass && !range_dis_ff |=> protection_violation_flag_ff)
        else $error("mass erase not refused");
    viol_block_a: assert property (@(posedge CLK) disable iff (RST) // see [R19]
        protection_violation_flag_ff && CMD_REQ.valid |=> !CMD_GO.valid)
        else $error("launch while violation set");

    // Further named steps
    sequence prot_write_s;
        WR && sel(ADDR, OFS_PROT);
    endsequence
    sequence viol_clear_s;
        WR && sel(ADDR, OFS_STATUS) && WDATA[PROTECTION_VIOLATION_FLAG_BIT];
    endsequence
    sequence cmd_s;
        CMD_REQ.valid;
    endsequence

    // Divider and tick checks
    div_first_a: assert property (@(posedge CLK) disable iff (RST) // see [R2]
        div_write_s ##0 !div_loaded_ff |=> {div_loaded_ff, div_ff} == ($past(WDATA) | 8'h80))
        else $error("first divider write not taken");
    div_hold_a: assert property (@(posedge CLK) disable iff (RST) // see [R20]
        div_loaded_ff |=> $stable(div_ff) && div_loaded_ff)
        else $error("divider lock released without reset");
    loaded_read_a: assert property (@(posedge CLK) disable iff (RST) // see [R1]
        RD && sel(ADDR, OFS_CLKDIV) |=> RDATA[DIV_LOADED_BIT] == $past(div_loaded_ff))
        else $error("loaded bit read wrong");
    tick_idle_a: assert property (@(posedge CLK) disable iff (RST) // see [R3]
        !div_loaded_ff |=> !ALGO_TICK)
        else $error("tick before divider written");
    tick_pulse_a: assert property (@(posedge CLK) disable iff (RST) // see [R3]
        ALGO_TICK |=> !ALGO_TICK)
        else $error("tick longer than one cycle");

    // Test and configuration registers
    test_b_zero_a: assert property (@(posedge CLK) disable iff (RST) // see [R5]
        RD && sel(ADDR, OFS_TEST_B) |=> RDATA == 8'h00)
        else $error("test register read nonzero");
    cfg_read_a: assert property (@(posedge CLK) disable iff (RST) // see [R6]
        RD && sel(ADDR, OFS_CONFIG) |=> RDATA[5:0] == 6'h00)
        else $error("config low bits not zero");
    cfg_write_a: assert property (@(posedge CLK) disable iff (RST) // see [R6]
        WR && sel(ADDR, OFS_CONFIG) |=> {irq_en_ff, 6'h00} == ($past(WDATA) & 8'hC0))
        else $error("enables not written");
    be_gate_a: assert property (@(posedge CLK) disable iff (RST) // see [R7]
        irq_en_ff[1] && BUFFER_EMPTY |-> IRQ)
        else $error("buffer empty interrupt missing");
    cc_gate_a: assert property (@(posedge CLK) disable iff (RST) // see [R8]
        irq_en_ff[0] && COMMAND_COMPLETE |-> IRQ)
        else $error("complete interrupt missing");

    // Protection register
    prot_load_a: assert property (@(posedge CLK) // see [R9]
        RST |=> {open_ff, nv_ff, range_dis_ff, size_ff} == $past(PROT_BYTE))
        else $error("protection not loaded in reset");
    nv_fixed_a: assert property (@(posedge CLK) disable iff (RST) // see [R10]
        1'b1 |=> $stable(nv_ff))
        else $error("user flags changed");
    prot_read_a: assert property (@(posedge CLK) disable iff (RST) // see [R10]
        RD && sel(ADDR, OFS_PROT) |=> RDATA[6:4] == $past(nv_ff))
        else $error("user flags read wrong");
    dis_sticky_a: assert property (@(posedge CLK) disable iff (RST) // see [R11]
        !range_dis_ff |=> !range_dis_ff)
        else $error("disable bit set by software");
    open_clear_a: assert property (@(posedge CLK) disable iff (RST) // see [R11]
        prot_write_s ##0 !WDATA[OPEN_BIT] |=> !open_ff)
        else $error("open bit not cleared");
    dis_clear_a: assert property (@(posedge CLK) disable iff (RST) // see [R11]
        prot_write_s ##0 !WDATA[RANGE_DIS_BIT] |=> !range_dis_ff)
        else $error("disable bit not cleared");

    // Command path
    range_refuse_a: assert property (@(posedge CLK) disable iff (RST) // see [R15]
        cmd_s ##0 (open_ff && !range_dis_ff
            && CMD_REQ.addr[10:6] >= 5'h1F - {2'b00, size_ff})
        |=> CMD_REFUSED && protection_violation_flag_ff)
        else $error("protected range accepted");
    open_accept_a: assert property (@(posedge CLK) disable iff (RST) // see [R14]
        cmd_s ##0 (open_ff && range_dis_ff && !protection_violation_flag_ff) |=> CMD_GO.valid && !CMD_REFUSED)
        else $error("unprotected command refused");
    one_answer_a: assert property (@(posedge CLK) disable iff (RST) // see [R16]
        cmd_s |=> CMD_GO.valid != CMD_REFUSED)
        else $error("command not answered once");
    no_answer_a: assert property (@(posedge CLK) disable iff (RST) // see [R16]
        !CMD_REQ.valid |=> !CMD_GO.valid && !CMD_REFUSED)
        else $error("answer without request");
    viol_refuse_a: assert property (@(posedge CLK) disable iff (RST) // see [R19]
        cmd_s ##0 protection_violation_flag_ff |=> CMD_REFUSED)
        else $error("refusal missing while violation set");
    viol_clear_a: assert property (@(posedge CLK) disable iff (RST) // see [R19]
        viol_clear_s ##0 !(CMD_REQ.valid && prot_hit) |=> !protection_violation_flag_ff)
        else $error("violation not cleared");
    viol_hold_a: assert property (@(posedge CLK) disable iff (RST) // see [R19]
        protection_violation_flag_ff && !(WR && sel(ADDR, OFS_STATUS) && WDATA[PROTECTION_VIOLATION_FLAG_BIT]) |=> protection_violation_flag_ff)
        else $error("violation lost without clear");
    status_read_a: assert property (@(posedge CLK) disable iff (RST) // see [R19]
        RD && sel(ADDR, OFS_STATUS) |=> RDATA[PROTECTION_VIOLATION_FLAG_BIT] == $past(protection_violation_flag_ff))
        else $error("violation flag read wrong");
endmodule

// ===== eep_regs_tb.sv
// Self-checking testbench for the emulated EEPROM control register bank
`timescale 1ns/1ps
module eep_regs_tb;
import eep_pkg::*;
logic CLK, RST, OSC_CLK_IN, WR, RD, BUFFER_EMPTY, COMMAND_COMPLETE, CMD_REFUSED, ALGO_TICK, IRQ;
logic [3:0] ADDR;
logic [7:0] WDATA, RDATA, PROT_BYTE, prot_m;
eep_req_t CMD_REQ, CMD_GO;
int failures, n_tests, g, i;
logic [31:0] seed, d;
logic protection_violation_flag_m;
logic [2:0] osc_cnt;
logic osc_slow;

eep_regs dut (.CLK(CLK), .RST(RST), .OSC_CLK_IN(OSC_CLK_IN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PROT_BYTE(PROT_BYTE), .CMD_REQ(CMD_REQ),
    .BUFFER_EMPTY(BUFFER_EMPTY), .COMMAND_COMPLETE(COMMAND_COMPLETE), .CMD_GO(CMD_GO),
    .CMD_REFUSED(CMD_REFUSED), .ALGO_TICK(ALGO_TICK), .IRQ(IRQ));

initial begin
    CLK = 0;
    forever #2.5 CLK = ~CLK;
end

// Oscillator of 4 or 16 bus cycles a period, below the sampling limit
always @(posedge CLK) begin
    if (osc_cnt >= (osc_slow ? 3'h7 : 3'h1)) begin
        osc_cnt <= 3'h0;
        OSC_CLK_IN <= ~OSC_CLK_IN;
    end else begin
        osc_cnt <= osc_cnt + 3'h1;
    end
end

function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction

task summarize;
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask

task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
        failures++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask

task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
endtask

task rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
endtask

// Model decides refusal before the request, as the block sees old state
task cmd(input logic [10:0] a, input logic m);
    logic hit, ref_m;
    int lim;
    lim = 2048 - (int'(prot_m[2:0]) + 1) * PROT_UNIT_BYTES;
    hit = !prot_m[7] || (!prot_m[3] && (m || int'(a) >= lim));
    ref_m = hit || protection_violation_flag_m;
    protection_violation_flag_m = protection_violation_flag_m || hit;
    @(posedge CLK);
    CMD_REQ <= '{valid: 1'b1, mass: m, addr: a};
    @(posedge CLK);
    CMD_REQ.valid <= 1'b0;
    #1 chk({7'h0, CMD_GO.valid}, {7'h0, !ref_m});
    chk({7'h0, CMD_REFUSED}, {7'h0, ref_m});
    if (!ref_m) chk(CMD_GO.addr[7:0], a[7:0]);
    if (!ref_m) chk({4'h0, CMD_GO.mass, CMD_GO.addr[10:8]}, {4'h0, m, a[10:8]});
    rdchk(OFS_STATUS, {BUFFER_EMPTY, COMMAND_COMPLETE, protection_violation_flag_m, 5'h0});
endtask

task wait_tick(output int n);
    n = 0;
    do begin
        @(posedge CLK);
        #1 n++;
    end while (ALGO_TICK !== 1'b1 && n < 3000);
    if (n >= 3000) begin
        failures++;
        summarize;
    end
endtask

initial begin
    RST = 1;
    WR = 0;
    RD = 0;
    ADDR = 0;
    WDATA = 0;
    PROT_BYTE = 8'hDB;
    CMD_REQ = '0;
    BUFFER_EMPTY = 0;
    COMMAND_COMPLETE = 0;
    OSC_CLK_IN = 0;
    osc_cnt = 0;
    osc_slow = 0;
    failures = 0;
    n_tests = 0;
    protection_violation_flag_m = 0;
    prot_m = 8'hDB;
    seed = 57;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rdchk(OFS_CLKDIV, 8'h00);
    rdchk(OFS_PROT, 8'hDB);
    // Prescale on, divide by 36: 50 MHz oscillator gives about 174 kHz
    wr(OFS_CLKDIV, 8'h63);
    rdchk(OFS_CLKDIV, 8'hE3);
    wr(OFS_CLKDIV, 8'h05);
    rdchk(OFS_CLKDIV, 8'hE3);
    wait_tick(g);
    wait_tick(g);
    // 36 * 8 oscillator periods of 4 bus cycles is 1152 cycles
    chk(8'(g >> 8), 8'h04);
    chk(8'(g), 8'h80);
    for (i = 0; i < 16; i++) begin
        if (!(i inside {0, 3, 4, 5, 6, 8, 9})) begin
            d = xs();
            wr(4'(i), d[7:0]);
            rdchk(4'(i), 8'h00);
        end
    end
    d = xs();
    wr(OFS_CMD, d[7:0]);
    wr(OFS_ADDR_HI, d[15:8]);
    wr(OFS_ADDR_LO, d[23:16]);
    rdchk(OFS_CMD, d[7:0]);
    rdchk(OFS_ADDR_HI, {5'h00, d[10:8]});
    rdchk(OFS_ADDR_LO, d[23:16]);
    for (i = 0; i < 16; i++) begin
        wr(OFS_CONFIG, {i[3:2], 6'h3F});
        rdchk(OFS_CONFIG, {i[3:2], 6'h00});
        @(posedge CLK);
        BUFFER_EMPTY <= i[1];
        COMMAND_COMPLETE <= i[0];
        @(posedge CLK);
        #1 chk({7'h0, IRQ}, {7'h0, (i[3] & i[1]) | (i[2] & i[0])});
    end
    wr(OFS_PROT, 8'hFF);
    rdchk(OFS_PROT, 8'hDF);
    wr(OFS_PROT, 8'h8D);
    rdchk(OFS_PROT, 8'hDD);
    prot_m = 8'hDD;
    cmd(11'h7FF, 1'b1);
    cmd(PROT_BYTE_ADDR, 1'b0);
    for (i = 0; i < 4; i++) begin
        d = xs();
        cmd(d[10:0], d[11]);
    end
    wr(OFS_PROT, 8'h85);
    wr(OFS_PROT, 8'h8B);
    rdchk(OFS_PROT, 8'hD5);
    prot_m = 8'hD5;
    cmd(11'h67F, 1'b0);
    cmd(11'h680, 1'b0);
    cmd(11'h100, 1'b0);
    wr(OFS_STATUS, 8'h00);
    rdchk(OFS_STATUS, {BUFFER_EMPTY, COMMAND_COMPLETE, 1'b1, 5'h0});
    for (i = 0; i < 24; i++) begin
        if (protection_violation_flag_m) begin
            wr(OFS_STATUS, 8'h20);
            protection_violation_flag_m = 0;
        end
        d = xs();
        cmd(d[10:0], d[15:12] == 4'h0);
    end
    wr(OFS_PROT, 8'h0D);
    prot_m = 8'h55;
    rdchk(OFS_PROT, 8'h55);
    wr(OFS_STATUS, 8'h20);
    protection_violation_flag_m = 0;
    cmd(11'h000, 1'b0);
    @(posedge CLK);
    RST <= 1'b1;
    PROT_BYTE <= 8'h88;
    osc_slow <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    protection_violation_flag_m = 0;
    prot_m = 8'h88;
    rdchk(OFS_PROT, 8'h88);
    rdchk(OFS_STATUS, {BUFFER_EMPTY, COMMAND_COMPLETE, protection_violation_flag_m, 5'h0});
    rdchk(OFS_CLKDIV, 8'h00);
    // Direct 12.5 MHz oscillator divided by 64 gives about 195 kHz
    wr(OFS_CLKDIV, 8'h3F);
    rdchk(OFS_CLKDIV, 8'hBF);
    wait_tick(g);
    wait_tick(g);
    chk(8'(g >> 8), 8'h04);
    chk(8'(g), 8'h00);
    cmd(11'h7C0, 1'b0);
    summarize;
end
endmodule
